// File: verilog/gpc_pkg.sv
/*
  Package for the general pin control block: register index and address,
  field positions, pin state codes, serial port timing and carrier types.
  Assumes a 200 MHz system clock and a 32-bit APB register bus.
*/
`default_nettype none

package gpc_pkg;

  // Register map, printed offset is a word index
  localparam logic [11:0] GPC_REG_INDEX = 12'h006;
  localparam logic [11:0] GPC_REG_ADDR = 12'h018;
  localparam logic [23:0] GPC_REG_RESET = 24'h000000;
  // Software-writable bits: word framing, enable, per-pin state and output
  localparam logic [23:0] GPC_WRITE_MASK = 24'h05EEEE;

  // Field positions
  localparam int GPC_WORD_FRAMING_BIT = 18;
  localparam int GPC_PORT_ENABLE_BIT = 16;
  localparam int GPC_PIN_FIELD_BITS = 4;
  localparam int GPC_STATE_LSB = 2;
  localparam int GPC_OUTPUT_BIT = 1;
  localparam int GPC_INPUT_BIT = 0;
  localparam int GPC_PIN_COUNT = 4;
  localparam int GPC_PORT_PINS = 3;

  // Pin state codes
  localparam logic [1:0] GPC_STATE_HIGHZ = 2'h0;
  localparam logic [1:0] GPC_STATE_INPUT = 2'h1;
  localparam logic [1:0] GPC_STATE_OUTPUT = 2'h2;
  localparam logic [1:0] GPC_STATE_OPEN_DRAIN = 2'h3;

  // Serial port pin assignment
  localparam int GPC_PIN_SELECT = 0;
  localparam int GPC_PIN_SCLK = 1;
  localparam int GPC_PIN_DATA = 2;

  // Timing
  localparam int GPC_CLK_PERIOD_PS = 5000;
  localparam longint GPC_FRAME_RATE_HZ = 128000;
  localparam int GPC_FRAME_CYCLES =
    int'(64'd1000000000000 / (longint'(GPC_CLK_PERIOD_PS) * GPC_FRAME_RATE_HZ));
  localparam int GPC_SCLK_HALF_PS = 10000;
  localparam int GPC_SCLK_HALF_CYCLES = (GPC_SCLK_HALF_PS / GPC_CLK_PERIOD_PS < 1) ? 1 :
    GPC_SCLK_HALF_PS / GPC_CLK_PERIOD_PS;
  localparam int GPC_WORD_BITS = 24;

  // One pin's field in the control register
  typedef struct packed {
    logic [1:0] state;
    logic out_value;
    logic in_value;
  } gpc_pin_field_type;

  // Control register layout
  typedef struct packed {
    logic [4:0] reserved_hi;
    logic word_framing;
    logic reserved_mid;
    logic port_enable;
    gpc_pin_field_type [GPC_PIN_COUNT-1:0] pin;
  } gpc_control_type;

  // One ECG word for the secondary port
  typedef struct packed {
    logic [GPC_WORD_BITS-1:0] data;
    logic last;
  } gpc_stream_word_type;

  // Serial port states
  typedef enum logic [2:0] {
    GPC_IDLE,
    GPC_LOAD,
    GPC_SHIFT_LOW,
    GPC_SHIFT_HIGH,
    GPC_GAP
  } gpc_port_state_type;

endpackage

`default_nettype wire

// File: verilog/gpc_pin_control.sv
/*
  General pin control block: one 24-bit control register on APB, four
  bidirectional pins with per-pin state, and a secondary serial port that
  takes over the first three pins to stream ECG words.
  Assumes pin inputs are asynchronous, ECG words arrive on CLK with a
  valid/ready handshake, and the APB master follows the standard protocol.
*/
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`default_nettype none

module gpc_pin_control (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] PIN_IN,
  output logic [3:0] PIN_OUT,
  output logic [3:0] PIN_OE,
  input wire gpc_pkg::gpc_stream_word_type ECG_WORD,
  input wire logic ECG_VALID,
  output logic ECG_READY,
  output logic PORT_BUSY
);

  // Field slice of one pin in the control register
  function automatic gpc_pkg::gpc_pin_field_type pin_field(
    input gpc_pkg::gpc_control_type ctl,
    input int idx
  );
    pin_field = ctl.pin[idx];
  endfunction

  // Address match for the single control word
  function automatic logic reg_hit(input logic [11:0] addr);
    reg_hit = (addr == gpc_pkg::GPC_REG_ADDR);
  endfunction

  gpc_pkg::gpc_control_type ctl_reg;
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [31:0] rdata_reg;
  logic [23:0] read_value;
  logic setup_phase;
  logic access_phase;

  gpc_pkg::gpc_port_state_type port_state_reg;
  gpc_pkg::gpc_port_state_type port_state_next;
  logic [15:0] tick_count_reg;
  logic frame_pending_reg;
  logic frame_tick;
  logic [7:0] half_count_reg;
  logic half_done;
  logic [4:0] bit_count_reg;
  logic [gpc_pkg::GPC_WORD_BITS-1:0] shift_reg;
  logic word_last_reg;
  logic select_n_reg;
  logic sclk_reg;
  logic frame_start;
  logic take_word;

  // APB phases
  assign setup_phase = PSEL & ~PENABLE;
  assign access_phase = PSEL & PENABLE;
  assign PREADY = 1'b1;
  assign PSLVERR = access_phase & ~reg_hit(PADDR);

  // Two-flop synchroniser on the pin inputs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= PIN_IN;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Control register write, only software-writable bits stored
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctl_reg <= gpc_pkg::GPC_REG_RESET;
    end else if (access_phase && PWRITE && reg_hit(PADDR)) begin
      ctl_reg <= (PWDATA[23:0] & gpc_pkg::GPC_WRITE_MASK);
    end
  end

  // Read value: stored bits plus live input bits
  always_comb begin
    gpc_pkg::gpc_pin_field_type fld_r;
    fld_r = '0;
    read_value = ctl_reg & gpc_pkg::GPC_WRITE_MASK;
    for (int i = 0; i < gpc_pkg::GPC_PIN_COUNT; i++) begin
      fld_r = pin_field(ctl_reg, i);
      if (fld_r.state == gpc_pkg::GPC_STATE_INPUT &&
          !(ctl_reg.port_enable && i < gpc_pkg::GPC_PORT_PINS)) begin
        read_value[i*gpc_pkg::GPC_PIN_FIELD_BITS + gpc_pkg::GPC_INPUT_BIT] =
          pin_sync_reg[i];
      end
    end
  end

  // Read data captured in the setup cycle, zero when unmapped
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= 32'h00000000;
    end else if (setup_phase) begin
      rdata_reg <= reg_hit(PADDR) ? {8'h00, read_value} : 32'h00000000;
    end
  end
  assign PRDATA = rdata_reg;

  // Frame rate tick at 128 kHz
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tick_count_reg <= 16'h0000;
    end else if (frame_tick) begin
      tick_count_reg <= 16'h0000;
    end else begin
      tick_count_reg <= tick_count_reg + 16'h0001;
    end
  end
  assign frame_tick = (tick_count_reg == 16'(gpc_pkg::GPC_FRAME_CYCLES - 1));

  // Pending frame slot, a new tick wins over the frame start
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      frame_pending_reg <= 1'b0;
    end else if (frame_tick) begin
      frame_pending_reg <= 1'b1;
    end else if (frame_start || !ctl_reg.port_enable) begin
      frame_pending_reg <= 1'b0;
    end
  end

  assign frame_start = (port_state_reg == gpc_pkg::GPC_IDLE) && frame_pending_reg &&
    ctl_reg.port_enable && ECG_VALID;
  assign take_word = (port_state_reg == gpc_pkg::GPC_LOAD) && ECG_VALID;
  assign ECG_READY = take_word;
  assign PORT_BUSY = (port_state_reg != gpc_pkg::GPC_IDLE);

  // Half-period counter of the serial clock
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      half_count_reg <= 8'h00;
    end else if (port_state_reg == gpc_pkg::GPC_IDLE ||
                 port_state_reg == gpc_pkg::GPC_LOAD || half_done) begin
      half_count_reg <= 8'h00;
    end else begin
      half_count_reg <= half_count_reg + 8'h01;
    end
  end
  assign half_done = (half_count_reg == 8'(gpc_pkg::GPC_SCLK_HALF_CYCLES - 1));

  // Serial port sequencing
  always_comb begin
    port_state_next = port_state_reg;
    case (port_state_reg)
      gpc_pkg::GPC_IDLE: begin
        if (frame_start) begin
          port_state_next = gpc_pkg::GPC_LOAD;
        end
      end
      gpc_pkg::GPC_LOAD: begin
        if (!ctl_reg.port_enable) begin
          port_state_next = gpc_pkg::GPC_IDLE;
        end else if (take_word) begin
          port_state_next = gpc_pkg::GPC_SHIFT_LOW;
        end
      end
      gpc_pkg::GPC_SHIFT_LOW: begin
        if (half_done) begin
          port_state_next = gpc_pkg::GPC_SHIFT_HIGH;
        end
      end
      gpc_pkg::GPC_SHIFT_HIGH: begin
        if (half_done) begin
          if (bit_count_reg != 5'h00) begin
            port_state_next = gpc_pkg::GPC_SHIFT_LOW;
          end else if (word_last_reg || !ctl_reg.port_enable) begin
            port_state_next = gpc_pkg::GPC_IDLE;
          end else if (ctl_reg.word_framing) begin
            port_state_next = gpc_pkg::GPC_GAP;
          end else begin
            port_state_next = gpc_pkg::GPC_LOAD;
          end
        end
      end
      gpc_pkg::GPC_GAP: begin
        if (half_done) begin
          port_state_next = gpc_pkg::GPC_LOAD;
        end
      end
      default: begin
        port_state_next = gpc_pkg::GPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      port_state_reg <= gpc_pkg::GPC_IDLE;
    end else begin
      port_state_reg <= port_state_next;
    end
  end

  // Shift register and bit count, MSB first, data changes with falling SCLK
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      shift_reg <= '0;
      word_last_reg <= 1'b0;
      bit_count_reg <= 5'h00;
    end else if (take_word) begin
      shift_reg <= ECG_WORD.data;
      word_last_reg <= ECG_WORD.last;
      bit_count_reg <= 5'(gpc_pkg::GPC_WORD_BITS - 1);
    end else if (port_state_reg == gpc_pkg::GPC_SHIFT_HIGH && half_done &&
                 bit_count_reg != 5'h00) begin
      shift_reg <= {shift_reg[gpc_pkg::GPC_WORD_BITS-2:0], 1'b0};
      bit_count_reg <= bit_count_reg - 5'h01;
    end
  end

  // Serial clock, high in the second half of each bit
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sclk_reg <= 1'b0;
    end else begin
      sclk_reg <= (port_state_next == gpc_pkg::GPC_SHIFT_HIGH);
    end
  end

  // Chip select, active low; frame-wide or per word
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      select_n_reg <= 1'b1;
    end else begin
      select_n_reg <= (port_state_next == gpc_pkg::GPC_IDLE) ||
        (port_state_next == gpc_pkg::GPC_GAP);
    end
  end

  // Pin drivers
  always_comb begin
    gpc_pkg::gpc_pin_field_type fld_d;
    fld_d = '0;
    PIN_OUT = 4'h0;
    PIN_OE = 4'h0;
    for (int i = 0; i < gpc_pkg::GPC_PIN_COUNT; i++) begin
      fld_d = pin_field(ctl_reg, i);
      case (fld_d.state)
        gpc_pkg::GPC_STATE_HIGHZ: begin
          PIN_OE[i] = 1'b0;
        end
        gpc_pkg::GPC_STATE_INPUT: begin
          PIN_OE[i] = 1'b0;
        end
        gpc_pkg::GPC_STATE_OUTPUT: begin
          PIN_OE[i] = 1'b1;
          PIN_OUT[i] = fld_d.out_value;
        end
        gpc_pkg::GPC_STATE_OPEN_DRAIN: begin
          PIN_OE[i] = ~fld_d.out_value;
          PIN_OUT[i] = 1'b0;
        end
        default: begin
          PIN_OE[i] = 1'b0;
        end
      endcase
    end
    // Serial port overrides the first three pins only
    if (ctl_reg.port_enable) begin
      PIN_OE[gpc_pkg::GPC_PORT_PINS-1:0] = 3'h7;
      PIN_OUT[gpc_pkg::GPC_PIN_SELECT] = select_n_reg;
      PIN_OUT[gpc_pkg::GPC_PIN_SCLK] = sclk_reg;
      PIN_OUT[gpc_pkg::GPC_PIN_DATA] = shift_reg[gpc_pkg::GPC_WORD_BITS-1];
    end
  end

endmodule

`default_nettype wire

// File: verif/gpc_pin_control_sva.sv
/* Checker for the pin control block: pin drive from the control word and
   serial port timing. Assumes it sees the block's ports, bound by the bench. */
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_control_sva (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PIN_OUT,
  input wire logic [3:0] PIN_OE,
  input wire gpc_pkg::gpc_stream_word_type ECG_WORD,
  input wire logic ECG_READY,
  input wire logic PORT_BUSY
);
  logic [23:0] ctl_reg;
  logic [3:0] oe_x;
  logic [3:0] out_x;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Shadow of the control word
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctl_reg <= gpc_pkg::GPC_REG_RESET;
    end else if (PSEL && PENABLE && PWRITE && PADDR == gpc_pkg::GPC_REG_ADDR) begin
      ctl_reg <= PWDATA[23:0] & gpc_pkg::GPC_WRITE_MASK;
    end
  end
  // Expected drive of each pin from its own field
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      oe_x[i] = ctl_reg[4*i+3] & ~(ctl_reg[4*i+2] & ctl_reg[4*i+1]);
      out_x[i] = ctl_reg[4*i+3] & ~ctl_reg[4*i+2] & ctl_reg[4*i+1];
    end
  end
  // Serial clock high half and select gap
  sequence s_high;
    (PIN_OUT[1] && $stable(PIN_OUT[2]))[*2] ##1 !PIN_OUT[1];
  endsequence
  sequence s_gap;
    !PIN_OUT[0] ##1 PIN_OUT[0][*2];
  endsequence
  property p_own;
    !ctl_reg[16] |-> (PIN_OE == oe_x) && ((PIN_OUT & oe_x) == out_x);
  endproperty
  a_own: assert property (p_own)
    else $error("pin drive differs from its field");
  property p_keep;
    ctl_reg[16] |-> (PIN_OE[3] == oe_x[3]) && ((PIN_OUT[3] & oe_x[3]) == out_x[3]);
  endproperty
  a_keep: assert property (p_keep)
    else $error("fourth pin left its own field");
  property p_take;
    ctl_reg[16] |-> PIN_OE[2:0] == 3'h7;
  endproperty
  a_take: assert property (p_take)
    else $error("serial port pins not driven");
  property p_idle;
    ctl_reg[16] && !PORT_BUSY |-> PIN_OUT[0] && !PIN_OUT[1];
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle port not at rest levels");
  property p_load;
    ECG_READY |-> ctl_reg[16] && !PIN_OUT[0] && !PIN_OUT[1];
  endproperty
  a_load: assert property (p_load)
    else $error("word taken without select");
  property p_bit;
    ctl_reg[16] && $rose(PIN_OUT[1]) |-> s_high;
  endproperty
  a_bit: assert property (p_bit)
    else $error("serial clock high half wrong");
  property p_word;
    ECG_READY && ctl_reg[18] |-> ##96 s_gap;
  endproperty
  a_word: assert property (p_word)
    else $error("per word select timing wrong");
  property p_frame;
    ECG_READY && !ctl_reg[18] && !ECG_WORD.last |-> ##97 !PIN_OUT[0];
  endproperty
  a_frame: assert property (p_frame)
    else $error("select dropped inside frame");
  property p_last;
    ECG_READY && ECG_WORD.last |-> ##97 PIN_OUT[0];
  endproperty
  a_last: assert property (p_last)
    else $error("select held after last word");
endmodule
`default_nettype wire

// File: verif/gpc_far_end.sv
/* Far side of the pins: board wiring with pull-ups and a serial receiver.
   Assumes select active low, data sampled on serial clock rise. */
`timescale 1ns/100ps
`default_nettype none
module gpc_far_end (
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic ext_en,
  input wire logic [3:0] ext_val,
  output logic [3:0] pin_lvl,
  output logic [23:0] rx_word,
  output int rx_count,
  output int sel_falls
);
  int nb = 0;
  logic [23:0] sh;
  // Wire level: device drive, else outside driver, else pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : (ext_en ? ext_val[i] : 1'b1);
    end
  end
  // Word receiver, MSB first
  always @(posedge pin_lvl[1]) begin
    if (!pin_lvl[0]) begin
      sh = {sh[22:0], pin_lvl[2]};
      nb++;
      if (nb == 24) begin
        rx_word = sh;
        rx_count++;
        nb = 0;
      end
    end
  end
  // Select falls start a fresh word
  always @(negedge pin_lvl[0]) begin
    sel_falls++;
    nb = 0;
  end
endmodule
`default_nettype wire

// File: verif/gpc_pin_control_tb.sv
/* Bench for the pin control block: APB tasks, pin state and serial tests.
   Assumes the far-end model and checker beside the block. */
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_control_tb;
  logic clk, rst, psel, penable, pwrite, ecg_valid, ext_en, err;
  logic pready, pslverr, ecg_ready, port_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic [3:0] pin_in, pin_out, pin_oe, ext_val, exp_oe;
  logic [23:0] rx_word;
  gpc_pkg::gpc_stream_word_type ecg_word;
  int rx_count, sel_falls, f0, ts[2];
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  localparam logic [11:0] ADDR = gpc_pkg::GPC_REG_ADDR;
  gpc_pin_control gpc_pin_control_i (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .ECG_WORD(ecg_word), .ECG_VALID(ecg_valid), .ECG_READY(ecg_ready), .PORT_BUSY(port_busy));
  gpc_far_end gpc_far_end_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pin_lvl(pin_in), .rx_word(rx_word), .rx_count(rx_count),
    .sel_falls(sel_falls));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; read data and error land in rd and err
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk iff pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Hand one word to the serial port
  task automatic send(input logic [23:0] d, input logic l);
    @(posedge clk);
    ecg_word <= {d, l};
    ecg_valid <= 1'b1;
    @(posedge clk iff ecg_ready);
    ecg_valid <= 1'b0;
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Clock and hang limit
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      finish_test;
    end
  end
  // Test sequence
  initial begin
    {rst, psel, penable, pwrite, ecg_valid, ext_en} = 6'h20;
    {paddr, pwdata, ext_val} = '0;
    ecg_word = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR, 32'h0);
    chk(rd, 32'h0);
    chk({28'h0, pin_oe}, 32'h0);
    apb(1'b1, 12'h01C, 32'hFFFF);
    apb(1'b0, 12'h01C, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    ext_val <= 4'hA;
    for (int s = 0; s < 4; s++) begin
      for (int o = 0; o < 2; o++) begin
        w = {16'h0, {4{s[1:0], o[0], 1'b0}}};
        ext_en <= (s == 1);
        apb(1'b1, ADDR, w);
        repeat (4) @(posedge clk);
        apb(1'b0, ADDR, 32'h0);
        exp_oe = (s == 2 || (s == 3 && o == 0)) ? 4'hF : 4'h0;
        chk(rd, w | ((s == 1) ? 32'h1010 : 32'h0));
        chk({28'h0, pin_oe}, {28'h0, exp_oe});
        chk({28'h0, pin_in}, (s == 1) ? 32'hA : (s == 0) ? 32'hF : {28'h0, {4{o[0]}}});
      end
    end
    ext_val <= 4'h5;
    ext_en <= 1'b1;
    apb(1'b1, ADDR, 32'h0000A5C3);
    repeat (4) @(posedge clk);
    apb(1'b0, ADDR, 32'h0);
    chk(rd, 32'h0000A5C2);
    chk({28'h0, pin_oe}, 32'hA);
    chk({28'h0, pin_in}, 32'hD);
    ext_en <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, ADDR, {13'h0, m[0], 2'b01, 16'hAAAA});
      f0 = sel_falls;
      send(24'hC3A51E, 1'b0);
      ts[m] = cyc;
      send(24'h5A0F96, 1'b1);
      @(posedge clk iff !port_busy);
      chk({8'h0, rx_word}, 32'h5A0F96);
      chk(sel_falls - f0, (m == 1) ? 32'h2 : 32'h1);
      chk({28'h0, pin_oe}, 32'hF);
      chk({31'h0, pin_in[3]}, 32'h1);
    end
    chk(ts[1] - ts[0], 32'd1562);
    finish_test;
  end
endmodule
bind gpc_pin_control gpc_pin_control_sva gpc_pin_control_sva_i (.CLK(CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .ECG_WORD(ECG_WORD), .ECG_READY(ECG_READY),
  .PORT_BUSY(PORT_BUSY));
`default_nettype wire
